/* hdl/dit_pkg.sv */
package dit_pkg;
   // ----------------------------------------------------------------
   // sizes and timing
   // ----------------------------------------------------------------
   localparam int NT       = 2;                      // timers
   localparam int CW       = 16;                     // count width
   localparam int AW       = 8;                      // axi address width
   localparam int CLK_MHZ  = 200;                    // clk_sys rate
   localparam int TB0_US   = 1;                      // internal bases
   localparam int TB1_US   = 5;
   localparam int TB2_US   = 25;
   localparam int TB3_US   = 50;
   localparam int DIV_1US  = TB0_US * CLK_MHZ;       // cycles per 1 us tick
   localparam int DIV_5    = TB1_US / TB0_US;        // 1 us ticks per 5 us
   localparam int DIV_25   = TB2_US / TB1_US;        // 5 us ticks per 25 us
   localparam int DIV_50   = TB3_US / TB2_US;        // 25 us ticks per 50 us
   localparam int FILT_NS  = 5000;                   // input filter window
   localparam int FILT_CYC = FILT_NS * CLK_MHZ / 1000;
   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [AW-1:0] T_STRIDE = 8'h10;       // timer 1 = base + stride
   localparam logic [3:0]    O_CTRL   = 4'h0;
   localparam logic [3:0]    O_MODE   = 4'h4;
   localparam logic [3:0]    O_COUNT  = 4'h8;
   localparam logic [3:0]    O_RELOAD = 4'hc;
   localparam logic [AW-1:0] A_ISTAT  = 8'h20;
   localparam logic [AW-1:0] A_IMASK  = 8'h24;
   localparam logic [AW-1:0] A_STATUS = 8'h28;
   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_START = 0;
   localparam int CTRL_STOP  = 1;
   localparam int MODE_TB_W  = 3;                    // bits [2:0]
   localparam int MODE_GATE  = 3;
   localparam int MODE_PER   = 4;
   localparam int MODE_W     = 5;
   localparam logic [MODE_W-1:0] MODE_RST   = 5'h00;
   localparam logic [CW-1:0]     RELOAD_RST = 16'hffff;
   localparam logic [1:0]        RESP_OKAY  = 2'h0;
   localparam logic [1:0]        RESP_SLV   = 2'h2;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [MODE_TB_W-1:0] {
      TB_1US, TB_5US, TB_25US, TB_50US, TB_EXT
   } dit_tb_type;
   typedef struct packed {
      logic ext_clk;
      logic ext_gate;
   } dit_pin_in_type;
   typedef struct packed {
      logic run_state;
      logic gate_en;
   } dit_pin_out_type;
   typedef struct packed {
      logic          run;
      logic          gate_ok;
      logic          tick;
      logic          load;
      logic          periodic;
      logic [CW-1:0] load_val;
      logic [CW-1:0] reload;
   } dit_chan_ctl_type;
endpackage : dit_pkg

/* hdl/dit_sync.sv */
`timescale 1ns/100ps
module dit_sync
   import dit_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic din,
   input  wire logic filt_en,
   output logic      dout
);
   localparam int FW = $clog2(FILT_CYC + 1);
   typedef struct packed {
      logic          q1;
      logic          q2;
      logic [FW-1:0] cnt;
      logic          out;
   } dit_sync_st_type;
   dit_sync_st_type s_r, s_nxt;

   // two flops, then an optional stability filter
   always_comb begin
      s_nxt    = s_r;
      s_nxt.q1 = din;
      s_nxt.q2 = s_r.q1;
      if (!filt_en || s_r.q2 == s_r.out) begin
         s_nxt.cnt = '0;
         if (!filt_en) s_nxt.out = s_r.q2;
      end else if (s_r.cnt == FW'(FILT_CYC - 1)) begin
         s_nxt.cnt = '0;
         s_nxt.out = s_r.q2;
      end else begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end
      if (rst) s_nxt = '0;
   end

   always_ff @(posedge clk_sys) begin
      s_r <= s_nxt;
   end

   assign dout = s_r.out;
endmodule : dit_sync

/* hdl/dit_chan.sv */
`timescale 1ns/100ps
module dit_chan
   import dit_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire dit_chan_ctl_type ctl,
   output logic [CW-1:0]         count,
   output logic                  uflow
);
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          uf;
   } dit_chan_st_type;
   dit_chan_st_type s_r, s_nxt;

   // load, or count down one per selected tick while running and gated
   always_comb begin
      s_nxt    = s_r;
      s_nxt.uf = 1'b0;
      if (ctl.load) begin
         s_nxt.cnt = ctl.load_val;
      end else if (ctl.run && ctl.gate_ok && ctl.tick) begin
         if (s_r.cnt == '0) begin
            s_nxt.uf  = 1'b1;
            s_nxt.cnt = ctl.periodic ? ctl.reload : '1;
         end else begin
            s_nxt.cnt = s_r.cnt - 1'b1;
         end
      end
      if (rst) s_nxt = '0;
   end

   always_ff @(posedge clk_sys) begin
      s_r <= s_nxt;
   end

   assign count = s_r.cnt;
   assign uflow = s_r.uf;
endmodule : dit_chan

/* hdl/dit_top.sv */
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
// Function
// - two timers, each with a 16-bit count.
// - each timer serves as interval, pulse count or pulse-duration timer with an end interrupt.
// - each timer has a count clock input, a gate input, a running output and a gate-enable output.
// - each timer has its own addresses and is started, stopped, read and loaded alone.
// - reading a count never disturbs the counting.
// - a mode field picks one of four internal bases or the external tick.
// - a running timer counts down by one on each tick of its selected base.
// - internal bases are 1, 5, 25 and 50 us, divided from the system clock.
// - input filtering is chosen by a static jumper, not by software.
// - the mode register also holds a gate-enable bit, writable with the base.
// - in periodic mode the reload value refills the count at each underflow, with an interrupt.
// - in aperiodic mode underflow interrupts and wraps to a full 65536-tick count.
// - with the gate enabled, a running timer counts only while its gate is high.
module dit_top
   import dit_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   // axi4-lite slave
   input  wire logic [AW-1:0]          s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [AW-1:0]          s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // user pins
   input  wire dit_pin_in_type [NT-1:0]  pin_in,
   input  wire logic                     filt_jumper,
   output dit_pin_out_type [NT-1:0]      pin_out,
   output logic                          irq
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                         aw_got;
      logic [AW-1:0]                awaddr;
      logic                         w_got;
      logic [31:0]                  wdata;
      logic [3:0]                   wstrb;
      logic                         awready;
      logic                         wready;
      logic                         bvalid;
      logic [1:0]                   bresp;
      logic                         arready;
      logic                         rvalid;
      logic [1:0]                   rresp;
      logic [31:0]                  rdata;
      logic [NT-1:0]                run;
      logic [NT-1:0][MODE_W-1:0]    mode;
      logic [NT-1:0][CW-1:0]        reload;
      logic [NT-1:0]                clk_q;
      logic [NT-1:0]                load;
      logic [NT-1:0][CW-1:0]        load_val;
      logic [7:0]                   pre;
      logic [2:0]                   c5;
      logic [2:0]                   c25;
      logic                         c50;
      logic [3:0]                   tick;
      logic [NT-1:0]                istat;
      logic [NT-1:0]                imask;
      logic                         irq;
      dit_pin_out_type [NT-1:0]     pins;
   } dit_top_st_type;

   dit_top_st_type          s_r, s_nxt;
   logic [NT-1:0]           clk_s;
   logic [NT-1:0]           gate_s;
   logic                    filt_s;
   logic [NT-1:0][CW-1:0]   cnt;
   logic [NT-1:0]           uflow;
   dit_chan_ctl_type [NT-1:0] ctl;

   // ----------------------------------------------------------------
   // byte-lane merge for register writes
   // ----------------------------------------------------------------
   function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) r[8*b +: 8] = new_v[8*b +: 8];
      end
      return r;
   endfunction : wmerge

   // ----------------------------------------------------------------
   // jumper strap and per-timer pins, channels
   // ----------------------------------------------------------------
   // static jumper picks the filter; no register can change it
   dit_sync u_strap (
      .clk_sys (clk_sys),
      .rst     (rst),
      .din     (filt_jumper),
      .filt_en (1'b0),
      .dout    (filt_s)
   );

   genvar gi;
   generate
      for (gi = 0; gi < NT; gi++) begin : g_tmr
         // count clock input, filtered when the jumper is fitted
         dit_sync u_clk (
            .clk_sys (clk_sys),
            .rst     (rst),
            .din     (pin_in[gi].ext_clk),
            .filt_en (filt_s),
            .dout    (clk_s[gi])
         );
         // gate input, same conditioning
         dit_sync u_gate (
            .clk_sys (clk_sys),
            .rst     (rst),
            .din     (pin_in[gi].ext_gate),
            .filt_en (filt_s),
            .dout    (gate_s[gi])
         );
         // one independent 16-bit counter per timer
         dit_chan u_chan (
            .clk_sys (clk_sys),
            .rst     (rst),
            .ctl     (ctl[gi]),
            .count   (cnt[gi]),
            .uflow   (uflow[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // channel controls: tick select and gating
   // ----------------------------------------------------------------
   always_comb begin
      for (int t = 0; t < NT; t++) begin
         ctl[t].run      = s_r.run[t];
         ctl[t].gate_ok  = !s_r.mode[t][MODE_GATE] || gate_s[t];
         ctl[t].load     = s_r.load[t];
         ctl[t].load_val = s_r.load_val[t];
         ctl[t].reload   = s_r.reload[t];
         ctl[t].periodic = s_r.mode[t][MODE_PER];
         case (dit_tb_type'(s_r.mode[t][MODE_TB_W-1:0]))
            TB_1US:  ctl[t].tick = s_r.tick[0];
            TB_5US:  ctl[t].tick = s_r.tick[1];
            TB_25US: ctl[t].tick = s_r.tick[2];
            TB_50US: ctl[t].tick = s_r.tick[3];
            TB_EXT:  ctl[t].tick = clk_s[t] && !s_r.clk_q[t];
            default: ctl[t].tick = 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic          wr_go;
      logic [AW-1:0] wa;
      logic [AW-1:0] ra;
      logic          ti;
      logic [31:0]   wv;
      logic [31:0]   rd;
      logic          rerr;
      logic          werr;
      logic [NT-1:0] clr;
      wr_go = 1'b0;
      wa    = '0;
      ra    = '0;
      ti    = 1'b0;
      wv    = '0;
      rd    = '0;
      rerr  = 1'b0;
      werr  = 1'b0;
      clr   = '0;
      s_nxt = s_r;

      // internal time bases: 1 us, then 5, 25 and 50 us from it
      s_nxt.tick = '0;
      if (s_r.pre == 8'(DIV_1US - 1)) begin
         s_nxt.pre     = '0;
         s_nxt.tick[0] = 1'b1;
         if (s_r.c5 == 3'(DIV_5 - 1)) begin
            s_nxt.c5      = '0;
            s_nxt.tick[1] = 1'b1;
            if (s_r.c25 == 3'(DIV_25 - 1)) begin
               s_nxt.c25     = '0;
               s_nxt.tick[2] = 1'b1;
               s_nxt.c50     = !s_r.c50;
               s_nxt.tick[3] = s_r.c50 == 1'(DIV_50 - 1);
            end else begin
               s_nxt.c25 = s_r.c25 + 1'b1;
            end
         end else begin
            s_nxt.c5 = s_r.c5 + 1'b1;
         end
      end else begin
         s_nxt.pre = s_r.pre + 1'b1;
      end

      // edge memory for the external count clock
      s_nxt.clk_q = clk_s;
      s_nxt.load  = '0;

      // write address and data, taken in either order
      if (s_axi_awvalid && s_r.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_r.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready) s_nxt.bvalid = 1'b0;

      // perform the write once both halves are held
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         wr_go        = 1'b1;
         wa           = s_r.awaddr;
         ti           = wa[4];
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got  = 1'b0;
         s_nxt.bvalid = 1'b1;
      end
      if (wr_go && wa[7:5] == 3'h0 && wa[1:0] == 2'h0) begin
         case (wa[3:0])
            O_CTRL: begin
               if (s_r.wstrb[0] && s_r.wdata[CTRL_START]) begin
                  s_nxt.run[ti] = 1'b1;
               end
               if (s_r.wstrb[0] && s_r.wdata[CTRL_STOP]) begin
                  s_nxt.run[ti] = 1'b0;
               end
            end
            O_MODE: begin
               wv = wmerge(32'(s_r.mode[ti]), s_r.wdata, s_r.wstrb);
               if (!s_r.run[ti]) s_nxt.mode[ti] = wv[MODE_W-1:0];
            end
            O_COUNT: begin
               wv = wmerge(32'(cnt[ti]), s_r.wdata, s_r.wstrb);
               if (!s_r.run[ti]) begin
                  s_nxt.load[ti]     = 1'b1;
                  s_nxt.load_val[ti] = wv[CW-1:0];
               end
            end
            default: begin
               wv = wmerge(32'(s_r.reload[ti]), s_r.wdata, s_r.wstrb);
               s_nxt.reload[ti] = wv[CW-1:0];
            end
         endcase
      end else if (wr_go) begin
         case (wa)
            A_ISTAT: clr = s_r.wstrb[0] ? s_r.wdata[NT-1:0] : '0;
            A_IMASK: begin
               if (s_r.wstrb[0]) s_nxt.imask = s_r.wdata[NT-1:0];
            end
            A_STATUS: ;
            default: werr = 1'b1;
         endcase
      end
      if (wr_go) s_nxt.bresp = werr ? RESP_SLV : RESP_OKAY;

      // read: a snapshot of the registers, counting goes on
      if (s_r.rvalid && s_axi_rready) s_nxt.rvalid = 1'b0;
      if (s_axi_arvalid && s_r.arready) begin
         ra = s_axi_araddr;
         ti = ra[4];
         if (ra[7:5] == 3'h0 && ra[1:0] == 2'h0) begin
            case (ra[3:0])
               O_CTRL:   rd[0] = s_r.run[ti];
               O_MODE:   rd[MODE_W-1:0] = s_r.mode[ti];
               O_COUNT:  rd[CW-1:0] = cnt[ti];
               default:  rd[CW-1:0] = s_r.reload[ti];
            endcase
         end else begin
            case (ra)
               A_ISTAT:  rd[NT-1:0] = s_r.istat;
               A_IMASK:  rd[NT-1:0] = s_r.imask;
               A_STATUS: rd[3*NT:0] = {filt_s, gate_s, clk_s, s_r.run};
               default:  rerr = 1'b1;
            endcase
         end
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata  = rd;
         s_nxt.rresp  = rerr ? RESP_SLV : RESP_OKAY;
      end

      // ready flags follow what is held
      s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
      s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;
      s_nxt.arready = !s_nxt.rvalid;

      // sticky end flags: a new underflow wins over a clear
      s_nxt.istat = (s_r.istat & ~clr) | uflow;
      s_nxt.irq   = |(s_nxt.istat & s_nxt.imask);

      // pins driven from registered state
      for (int t = 0; t < NT; t++) begin
         s_nxt.pins[t].run_state = s_nxt.run[t];
         s_nxt.pins[t].gate_en   = s_nxt.mode[t][MODE_GATE];
      end

      if (rst) begin
         s_nxt        = '0;
         s_nxt.mode   = {NT{MODE_RST}};
         s_nxt.reload = {NT{RELOAD_RST}};
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      s_r <= s_nxt;
   end

   // ----------------------------------------------------------------
   // outputs, all straight from flops
   // ----------------------------------------------------------------
   assign s_axi_awready = s_r.awready;
   assign s_axi_wready  = s_r.wready;
   assign s_axi_bvalid  = s_r.bvalid;
   assign s_axi_bresp   = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid  = s_r.rvalid;
   assign s_axi_rdata   = s_r.rdata;
   assign s_axi_rresp   = s_r.rresp;
   assign pin_out       = s_r.pins;
   assign irq           = s_r.irq;
endmodule : dit_top

/* sim/dit_top_asserts.sv */
`timescale 1ns/100ps
module dit_top_asserts
   import dit_pkg::*;
(
   input wire logic                    clk_sys,
   input wire logic                    rst,
   input wire logic                    s_axi_awvalid,
   input wire logic                    s_axi_awready,
   input wire logic                    s_axi_wvalid,
   input wire logic                    s_axi_wready,
   input wire logic [1:0]              s_axi_bresp,
   input wire logic                    s_axi_bvalid,
   input wire logic                    s_axi_bready,
   input wire logic                    s_axi_arvalid,
   input wire logic                    s_axi_arready,
   input wire logic [31:0]             s_axi_rdata,
   input wire logic [1:0]              s_axi_rresp,
   input wire logic                    s_axi_rvalid,
   input wire logic                    s_axi_rready,
   input wire dit_pin_out_type [NT-1:0] pin_out,
   input wire logic                    irq
);
   default clocking dit_cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // bus answers
   // ------------------------------------------------------------
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   a_slv_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLV
      |-> s_axi_rdata == '0) else $error("error read carries data");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer missing");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer not held");
   a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
      else $error("address taken during write");
   // ------------------------------------------------------------
   // pins and interrupt
   // ------------------------------------------------------------
   a_reset_quiet: assert property ($past(rst) |-> !s_axi_bvalid && !s_axi_rvalid
      && !irq && !s_axi_awready && pin_out == '0) else $error("outputs active after reset");
   a_pins_by_write: assert property (!$stable(pin_out) |-> $rose(s_axi_bvalid))
      else $error("pin moved without a write");
   a_irq_clear: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
      else $error("interrupt dropped without a write");
   c_slv_read: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLV);
   c_irq_rise: cover property ($rose(irq));
   c_run_rise: cover property ($rose(pin_out[1].run_state));
endmodule : dit_top_asserts
bind dit_top dit_top_asserts dit_top_asserts_inst (.*);

/* sim/dit_user_model.sv */
`timescale 1ns/100ps
module dit_user_model
   import dit_pkg::*;
(
   input  wire logic               clk_sys,
   output dit_pin_in_type [NT-1:0] pin_in
);
   // both timers' pins rest low until the bench asks for traffic
   initial pin_in = '0;
   // count pulses: 100 clocks high, 100 low, so never faster than 1 us
   task automatic pulse(input int t, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         pin_in[t].ext_clk <= 1'b1;
         repeat (100) @(posedge clk_sys);
         pin_in[t].ext_clk <= 1'b0;
         repeat (100) @(posedge clk_sys);
      end
   endtask : pulse
   // gate level, changed just after an edge
   task automatic gate(input int t, input logic v);
      @(posedge clk_sys);
      pin_in[t].ext_gate <= v;
   endtask : gate
endmodule : dit_user_model

/* sim/dual_interval_timer_tb.sv */
`timescale 1ns/100ps
module dual_interval_timer_tb
   import dit_pkg::*;
();
   logic                     clk_sys, rst, filt_jumper, irq;
   logic [AW-1:0]            s_axi_awaddr, s_axi_araddr;
   logic                     s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                     s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                     s_axi_rvalid, s_axi_rready;
   logic [31:0]              s_axi_wdata, s_axi_rdata;
   logic [3:0]               s_axi_wstrb;
   logic [1:0]               s_axi_bresp, s_axi_rresp;
   dit_pin_in_type [NT-1:0]  pin_in;
   dit_pin_out_type [NT-1:0] pin_out;
   logic [33:0]              exp_q[$];
   logic [15:0]              rnd;
   int                       fails, tests_run, cyc, t0, np;
   int                       seed = 32'ha854;
   int                       us_tab[4] = '{TB0_US, TB1_US, TB2_US, TB3_US};
   dit_top dit_top_inst (.*);
   dit_user_model dit_user_model_inst (.clk_sys(clk_sys), .pin_in(pin_in));
   // ------------------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------------------
   task automatic check(input logic [33:0] seen, input logic [33:0] want);
      tests_run++;
      if (seen !== want) begin
         fails++;
         $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic test_done;
      $display("checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   // one clock with a bound on the whole wait
   task automatic tick(inout int n);
      @(posedge clk_sys);
      n++;
      if (n > 12000) begin
         fails++;
         $display("CHECK FAILED t=%0t wait ran out", $time);
         test_done();
      end
   endtask : tick
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      exp_q.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         tick(n);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      tick(n);
   endtask : wr
   task automatic rd(input logic [AW-1:0] a, input logic [33:0] e);
      int n;
      n = 0;
      exp_q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         tick(n);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      tick(n);
   endtask : rd
   task automatic wait_irq;
      int n;
      n = 0;
      do tick(n); while (irq !== 1'b1);
   endtask : wait_irq
   function automatic logic [AW-1:0] ra(input int t, input logic [3:0] o);
      return AW'(t) * T_STRIDE + AW'(o);
   endfunction : ra
   // ------------------------------------------------------------
   // clock, cycle count and answer monitor
   // ------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) cyc <= cyc + 1;
   // each bus answer is held against the oldest expectation
   always @(posedge clk_sys) begin
      if (s_axi_rvalid && s_axi_rready)
         check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         check({s_axi_bresp, 32'h0}, exp_q.pop_front());
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {rst, filt_jumper, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = {1'b1, 49'h0};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_wstrb = 4'hf;
      rnd = 16'($random(seed));
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      // reset values and unmapped places
      for (int t = 0; t < NT; t++) begin
         rd(ra(t, O_MODE), {RESP_OKAY, 27'h0, MODE_RST});
         rd(ra(t, O_RELOAD), {RESP_OKAY, 16'h0, RELOAD_RST});
         rd(ra(t, O_COUNT), {RESP_OKAY, 32'h0});
      end
      rd(A_IMASK, {RESP_OKAY, 32'h0});
      rd(8'h2c, {RESP_SLV, 32'h0});
      rd(8'h01, {RESP_SLV, 32'h0});
      wr(8'h30, 32'h1, RESP_SLV);
      $display("test map done");
      // every internal base: cycles between two underflows with reload 0
      wr(A_IMASK, 32'h3, RESP_OKAY);
      for (int b = 0; b < 4; b++) begin
         wr(ra(0, O_MODE), 32'h10 | b, RESP_OKAY);
         wr(ra(0, O_RELOAD), 32'h0, RESP_OKAY);
         wr(ra(0, O_CTRL), 32'h1, RESP_OKAY);
         wait_irq();
         t0 = cyc;
         wr(A_ISTAT, 32'h1, RESP_OKAY);
         wait_irq();
         check(34'(cyc - t0), 34'(us_tab[b] * CLK_MHZ));
         wr(ra(0, O_CTRL), 32'h2, RESP_OKAY);
         wr(A_ISTAT, 32'h1, RESP_OKAY);
      end
      $display("test bases done");
      // aperiodic wrap, refused mode write, masking and clearing
      wr(ra(0, O_MODE), 32'h0, RESP_OKAY);
      wr(ra(0, O_COUNT), {30'h0, rnd[1:0]}, RESP_OKAY);
      wr(ra(0, O_CTRL), 32'h1, RESP_OKAY);
      check({33'h0, pin_out[0].run_state}, 34'h1);
      wr(ra(0, O_MODE), 32'h18, RESP_OKAY);
      rd(ra(0, O_MODE), {RESP_OKAY, 32'h0});
      rd(A_STATUS, {RESP_OKAY, 32'h1});
      wait_irq();
      wr(ra(0, O_CTRL), 32'h2, RESP_OKAY);
      check({33'h0, pin_out[0].run_state}, 34'h0);
      rd(ra(0, O_COUNT), {RESP_OKAY, 16'h0, 16'hffff});
      rd(ra(1, O_COUNT), {RESP_OKAY, 32'h0});
      wr(A_IMASK, 32'h0, RESP_OKAY);
      rd(A_ISTAT, {RESP_OKAY, 32'h1});
      check({33'h0, irq}, 34'h0);
      wr(A_ISTAT, 32'h1, RESP_OKAY);
      rd(A_ISTAT, {RESP_OKAY, 32'h0});
      $display("test wrap done");
      // external ticks on timer 1, held off until its gate opens
      np = 1 + rnd[4:2];
      wr(ra(1, O_RELOAD), {16'h0, rnd}, RESP_OKAY);
      rd(ra(1, O_RELOAD), {RESP_OKAY, 16'h0, rnd});
      wr(ra(1, O_MODE), 32'h0c, RESP_OKAY);
      rd(ra(1, O_MODE), {RESP_OKAY, 32'h0c});
      check({32'h0, pin_out[1].gate_en, pin_out[0].gate_en}, 34'h2);
      wr(ra(1, O_COUNT), 32'h20, RESP_OKAY);
      wr(ra(1, O_CTRL), 32'h1, RESP_OKAY);
      dit_user_model_inst.pulse(1, 3);
      rd(ra(1, O_COUNT), {RESP_OKAY, 32'h20});
      dit_user_model_inst.gate(1, 1'b1);
      repeat (5) @(posedge clk_sys);
      dit_user_model_inst.pulse(1, np);
      rd(ra(1, O_COUNT), {RESP_OKAY, 32'(32'h20 - np)});
      rd(ra(1, O_COUNT), {RESP_OKAY, 32'(32'h20 - np)});
      rd(ra(0, O_COUNT), {RESP_OKAY, 16'h0, 16'hffff});
      wr(ra(1, O_CTRL), 32'h2, RESP_OKAY);
      check({32'h0, pin_out[1].run_state, pin_out[0].run_state}, 34'h0);
      filt_jumper <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(A_STATUS, {RESP_OKAY, 32'h60});
      $display("test external done");
      test_done();
   end
endmodule : dual_interval_timer_tb
